// ### hw/dsa_map.vh
// Register map, field layout, encodings and counts of the dsp operand and alu slice
`ifndef DSA_MAP_VH
`define DSA_MAP_VH
// Byte offsets on the register bus
`define DSA_A_CMD 8'h00
`define DSA_A_PF 8'h04
`define DSA_A_FDATA 8'h08
`define DSA_A_XDATA 8'h0C
`define DSA_A_YDATA 8'h10
`define DSA_A_STATUS 8'h14
`define DSA_A_RESULT 8'h18
`define DSA_A_PFADDR 8'h1C
`define DSA_A_ACCA_LO 8'h20
`define DSA_A_ACCA_HI 8'h24
`define DSA_A_ACCB_LO 8'h28
`define DSA_A_ACCB_HI 8'h2C
`define DSA_A_WWIN 2'b01
`define DSA_HSIZE_WORD 3'b010
// Command word fields
`define DSA_CMD_OP 4:0
`define DSA_CMD_DSEL 5
`define DSA_CMD_SMODE 7:6
`define DSA_CMD_RB 11:8
`define DSA_CMD_RS 15:12
`define DSA_CMD_RD 19:16
`define DSA_CMD_LIT 24:20
`define DSA_CMD_W 25
// Prefetch word fields and modes
`define DSA_PF_XMODE 3:0
`define DSA_PF_XDST 5:4
`define DSA_PF_YMODE 11:8
`define DSA_PF_YDST 13:12
`define DSA_PF_W 14
`define DSA_PF_NONE 4'hF
`define DSA_PF_IDX 4'hE
`define DSA_PF_SPLIT 4'h7
// Fixed working registers
`define DSA_R_W0 4'h0
`define DSA_R_X0 4'h8
`define DSA_R_X1 4'h9
`define DSA_R_Y0 4'hA
`define DSA_R_Y1 4'hB
`define DSA_R_IDX 4'hC
// Source addressing modes
`define DSA_SM_DIR 2'b00
`define DSA_SM_IND 2'b01
`define DSA_SM_INC 2'b10
`define DSA_SM_DEC 2'b11
`define DSA_PTR_STEP 16'h0002
// Status word bits
`define DSA_ST_C 0
`define DSA_ST_Z 1
`define DSA_ST_OV 2
`define DSA_ST_N 3
`define DSA_ST_DC 4
`define DSA_ST_OA 8
`define DSA_ST_OB 9
`define DSA_ST_SA 10
`define DSA_ST_SB 11
// Opcodes
`define DSA_OP_NOP 5'h00
`define DSA_OP_ADD_F 5'h01
`define DSA_OP_ADD_WITH_CARRY_OP_F 5'h02
`define DSA_OP_ADD_RR 5'h03
`define DSA_OP_ADD_WITH_CARRY_OP_RR 5'h04
`define DSA_OP_ADD_L5 5'h05
`define DSA_OP_ADD_WITH_CARRY_OP_L5 5'h06
`define DSA_OP_ADD_ACC 5'h07
`define DSA_OP_ASR_F 5'h08
`define DSA_OP_ASR_RR 5'h09
`define DSA_OP_ASR_W 5'h0A
`define DSA_OP_ASR_L 5'h0B
`define DSA_OP_BIT_CLEAR_OP_F 5'h0C
`define DSA_OP_BIT_CLEAR_OP_W 5'h0D
`define DSA_OP_AND_F 5'h0E
`define DSA_OP_AND_RR 5'h0F
`define DSA_OP_BRA_GTU 5'h10
`define DSA_OP_BRA_GEU 5'h11
`define DSA_OP_BRA_GT 5'h12
`define DSA_OP_BRA_GE 5'h13
`define DSA_OP_MAC 5'h14
`define DSA_OP_SQR 5'h15
// Cycle counts
`define DSA_CYC_ONE 2'h1
`define DSA_CYC_TAKEN 2'h2
// Reset and limit values
`define DSA_RST_W 16'h0000
`define DSA_RST_ACC 40'h00_0000_0000
`define DSA_ACC_MAX 40'h7F_FFFF_FFFF
`define DSA_ACC_MIN 40'h80_0000_0000
`endif

// ### hw/dsa_add.v
// Adder with carry in and carry, digit carry, negative, overflow and zero outputs
`timescale 1ns/1ps
module dsa_add #(
  parameter DATA_W = 16
) (
  input wire [DATA_W-1:0] i_a,
  input wire [DATA_W-1:0] i_b,
  input wire i_cin,
  output wire [DATA_W-1:0] o_sum,
  output wire o_c,
  output wire o_dc,
  output wire o_n,
  output wire o_ov,
  output wire o_zero
);
  wire [DATA_W:0] full;
  wire [4:0] low;

  // Full width sum and low nibble sum
  assign full = {1'b0, i_a} + {1'b0, i_b} + {{DATA_W{1'b0}}, i_cin};
  assign low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
  assign o_sum = full[DATA_W-1:0];
  assign o_c = full[DATA_W];
  assign o_dc = low[4];
  assign o_n = full[DATA_W-1];
  // Same signs in, other sign out
  assign o_ov = (i_a[DATA_W-1] == i_b[DATA_W-1]) & (full[DATA_W-1] != i_a[DATA_W-1]);
  assign o_zero = (full[DATA_W-1:0] == {DATA_W{1'b0}});
endmodule

// ### hw/dsa_asr.v
// Arithmetic right shifter that keeps the sign and reports the last bit out
`timescale 1ns/1ps
module dsa_asr #(
  parameter DATA_W = 16,
  parameter SHIFT_W = 5
) (
  input wire [DATA_W-1:0] i_data,
  input wire [SHIFT_W-1:0] i_amt,
  output wire [DATA_W-1:0] o_res,
  output wire o_cout
);
  wire signed [DATA_W:0] ext;
  wire signed [DATA_W:0] shifted;

  // Guard bit below the lsb catches the last bit shifted out
  assign ext = $signed({i_data, 1'b0});
  assign shifted = ext >>> i_amt;
  assign o_res = shifted[DATA_W:1];
  assign o_cout = shifted[0];
endmodule

// ### hw/dsa_core.v
// Dsp operand and alu slice with its working registers behind an ahb-lite slave
`timescale 1ns/1ps
`include "dsa_map.vh"
module dsa_core (
  input wire i_clk,
  input wire i_resetn,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp
);
  localparam ST_IDLE = 2'b00;
  localparam ST_EXEC = 2'b01;
  localparam ST_NOP = 2'b10;

  // ************************************************************
  // State and decode
  // ************************************************************
  reg [15:0] w_ff [0:15];
  reg [15:0] nxt_w [0:15];
  reg [`DSA_CMD_W-1:0] cmd_ff;
  reg [`DSA_PF_W-1:0] pf_ff;
  reg [15:0] fdata_ff, xdata_ff, ydata_ff, result_ff, xaddr_ff, yaddr_ff;
  reg [39:0] acca_ff, accb_ff;
  reg c_ff, z_ff, ov_ff, n_ff, dc_ff, oa_ff, ob_ff, sa_ff, sb_ff, taken_ff, err_ff;
  reg [1:0] cyc_ff, state_ff;
  reg dph_valid_ff, dph_write_ff, dph_word_ff, rd_done_ff;
  reg [7:0] dph_addr_ff;
  reg [31:0] hrdata_ff, rd_mux;
  reg [15:0] nxt_result, nxt_xaddr, nxt_yaddr, res_v;
  reg [39:0] nxt_acca, nxt_accb;
  reg nxt_c, nxt_z, nxt_ov, nxt_n, nxt_dc, nxt_oa, nxt_ob, nxt_sa, nxt_sb;
  reg nxt_taken, nxt_err, wb_en, acc_en, pf_en, br_cond, pair_ok;
  reg [1:0] nxt_cyc;
  reg [3:0] mn;
  integer k;
  integer j;

  wire [4:0] op = cmd_ff[`DSA_CMD_OP];
  wire dsel = cmd_ff[`DSA_CMD_DSEL];
  wire [1:0] smode = cmd_ff[`DSA_CMD_SMODE];
  wire [3:0] rb = cmd_ff[`DSA_CMD_RB];
  wire [3:0] rs = cmd_ff[`DSA_CMD_RS];
  wire [3:0] rd = cmd_ff[`DSA_CMD_RD];
  wire [4:0] lit = cmd_ff[`DSA_CMD_LIT];
  wire [15:0] wb = w_ff[rb];
  wire [15:0] ws = w_ff[rs];
  wire [15:0] src = (smode == `DSA_SM_DIR) ? ws : fdata_ff;
  wire is_f = (op == `DSA_OP_ADD_F) | (op == `DSA_OP_ADD_WITH_CARRY_OP_F) | (op == `DSA_OP_ASR_F) |
              (op == `DSA_OP_BIT_CLEAR_OP_F) | (op == `DSA_OP_AND_F);
  wire is_cy = (op == `DSA_OP_ADD_WITH_CARRY_OP_F) | (op == `DSA_OP_ADD_WITH_CARRY_OP_RR) | (op == `DSA_OP_ADD_WITH_CARRY_OP_L5);
  wire is_l5 = (op == `DSA_OP_ADD_L5) | (op == `DSA_OP_ADD_WITH_CARRY_OP_L5);
  wire uses_src = (op == `DSA_OP_ADD_RR) | (op == `DSA_OP_ADD_WITH_CARRY_OP_RR) | (op == `DSA_OP_ASR_RR) |
                  (op == `DSA_OP_BIT_CLEAR_OP_W) | (op == `DSA_OP_AND_RR) | (op == `DSA_OP_ADD_ACC);

  // ************************************************************
  // Arithmetic units
  // ************************************************************
  wire [15:0] add_sum, asr_res;
  wire add_c, add_dc, add_n, add_ov, add_zero, asr_c;
  wire [15:0] add_a = is_f ? fdata_ff : wb;
  wire [15:0] add_b = is_f ? w_ff[`DSA_R_W0] : (is_l5 ? {11'h000, lit} : src);
  wire [15:0] asr_in = is_f ? fdata_ff : ((op == `DSA_OP_ASR_RR) ? src : wb);
  wire [4:0] asr_amt = (op == `DSA_OP_ASR_W) ? {1'b0, ws[3:0]} :
                       ((op == `DSA_OP_ASR_L) ? lit : 5'h01);
  wire [15:0] bit_clear_op_v = (is_f ? fdata_ff : src) & ~(16'h0001 << lit[3:0]);
  wire [15:0] and_v = is_f ? (fdata_ff & w_ff[`DSA_R_W0]) : (wb & src);

  dsa_add #(.DATA_W(16)) u_add (
    .i_a(add_a),
    .i_b(add_b),
    .i_cin(is_cy & c_ff),
    .o_sum(add_sum),
    .o_c(add_c),
    .o_dc(add_dc),
    .o_n(add_n),
    .o_ov(add_ov),
    .o_zero(add_zero)
  );

  dsa_asr #(.DATA_W(16), .SHIFT_W(5)) u_asr (
    .i_data(asr_in),
    .i_amt(asr_amt),
    .o_res(asr_res),
    .o_cout(asr_c)
  );

  // Saturating accumulator add: {saturated, overflow, sum}
  function [41:0] acc_add;
    input [39:0] a;
    input [39:0] b;
    reg [39:0] sum;
    reg [39:0] res;
    reg ovf;
    begin
      sum = a + b;
      ovf = (a[39] == b[39]) & (sum[39] != a[39]);
      res = ovf ? (a[39] ? `DSA_ACC_MIN : `DSA_ACC_MAX) : sum;
      acc_add = {ovf, ~((&res[39:31]) | ~(|res[39:31])), res};
    end
  endfunction

  // Post-modify step of a prefetch pointer
  function [15:0] pf_delta;
    input [2:0] m;
    begin
      case (m)
        3'h1: pf_delta = 16'h0002;
        3'h2: pf_delta = 16'h0004;
        3'h3: pf_delta = 16'h0006;
        3'h4: pf_delta = 16'hFFFE;
        3'h5: pf_delta = 16'hFFFC;
        3'h6: pf_delta = 16'hFFFA;
        default: pf_delta = 16'h0000;
      endcase
    end
  endfunction

  // square takes one of W4..W7 twice
  always @* begin
    pair_ok = 1'b1;
    mn = 4'h0;
    if (op == `DSA_OP_SQR) begin
      pair_ok = (rs[3:2] == 2'b00);
      mn = {rs[1:0], rs[1:0]};
    end else begin
      case (rs)
        4'h0: mn = 4'h1;
        4'h1: mn = 4'h2;
        4'h2: mn = 4'h3;
        4'h3: mn = 4'h6;
        4'h4: mn = 4'h7;
        4'h5: mn = 4'hB;
        default: pair_ok = 1'b0;
      endcase
    end
  end

  wire [15:0] mul_a = w_ff[{2'b01, mn[3:2]}];
  wire [15:0] mul_b = w_ff[{2'b01, mn[1:0]}];
  wire signed [31:0] prod = $signed(mul_a) * $signed(mul_b);
  wire signed [39:0] aa_base = $signed({{8{src[15]}}, src, 16'h0000});
  wire [3:0] sl_neg = 4'h0 - lit[3:0];
  wire [39:0] aa_sh = lit[3] ? (aa_base <<< sl_neg) : (aa_base >>> lit[3:0]);
  wire is_mul = (op == `DSA_OP_MAC) | (op == `DSA_OP_SQR);
  wire [39:0] acc_in = is_mul ? {{8{prod[31]}}, prod} : aa_sh;
  wire [41:0] acc_r = acc_add(dsel ? accb_ff : acca_ff, acc_in);

  // Prefetch pointer selection
  wire [3:0] xm = pf_ff[`DSA_PF_XMODE];
  wire [3:0] ym = pf_ff[`DSA_PF_YMODE];
  wire [3:0] xp = (xm < `DSA_PF_SPLIT) ? `DSA_R_X0 : `DSA_R_X1;
  wire [3:0] yp = (ym < `DSA_PF_SPLIT) ? `DSA_R_Y0 : `DSA_R_Y1;
  wire [3:0] xsub = (xm < `DSA_PF_SPLIT) ? xm : xm - `DSA_PF_SPLIT;
  wire [3:0] ysub = (ym < `DSA_PF_SPLIT) ? ym : ym - `DSA_PF_SPLIT;

  // ************************************************************
  // Instruction execution
  // ************************************************************
  always @* begin
    for (k = 0; k < 16; k = k + 1) begin
      nxt_w[k] = w_ff[k];
    end
    nxt_c = c_ff;
    nxt_z = z_ff;
    nxt_ov = ov_ff;
    nxt_n = n_ff;
    nxt_dc = dc_ff;
    nxt_oa = oa_ff;
    nxt_ob = ob_ff;
    nxt_sa = sa_ff;
    nxt_sb = sb_ff;
    nxt_err = err_ff;
    nxt_taken = 1'b0;
    nxt_cyc = `DSA_CYC_ONE;
    nxt_result = result_ff;
    nxt_acca = acca_ff;
    nxt_accb = accb_ff;
    nxt_xaddr = xaddr_ff;
    nxt_yaddr = yaddr_ff;
    res_v = 16'h0000;
    wb_en = 1'b0;
    acc_en = 1'b0;
    pf_en = 1'b0;
    br_cond = 1'b0;
    if (uses_src && smode == `DSA_SM_INC) begin
      nxt_w[rs] = ws + `DSA_PTR_STEP;
    end else if (uses_src && smode == `DSA_SM_DEC) begin
      nxt_w[rs] = ws - `DSA_PTR_STEP;
    end
    case (op)
      `DSA_OP_ADD_F, `DSA_OP_ADD_WITH_CARRY_OP_F, `DSA_OP_ADD_RR, `DSA_OP_ADD_WITH_CARRY_OP_RR,
      `DSA_OP_ADD_L5, `DSA_OP_ADD_WITH_CARRY_OP_L5: begin
        // add family flags in one cycle
        nxt_c = add_c;
        nxt_dc = add_dc;
        nxt_n = add_n;
        nxt_ov = add_ov;
        nxt_z = is_cy ? (z_ff & add_zero) : add_zero;
        res_v = add_sum;
        wb_en = 1'b1;
      end
      `DSA_OP_ASR_F, `DSA_OP_ASR_RR: begin
        nxt_c = asr_c;
        nxt_n = asr_res[15];
        nxt_ov = 1'b0;
        nxt_z = (asr_res == 16'h0000);
        res_v = asr_res;
        wb_en = 1'b1;
      end
      `DSA_OP_ASR_W, `DSA_OP_ASR_L: begin
        nxt_n = asr_res[15];
        nxt_z = (asr_res == 16'h0000);
        res_v = asr_res;
        wb_en = 1'b1;
      end
      `DSA_OP_BIT_CLEAR_OP_F, `DSA_OP_BIT_CLEAR_OP_W: begin
        res_v = bit_clear_op_v;
        wb_en = 1'b1;
      end
      `DSA_OP_AND_F, `DSA_OP_AND_RR: begin
        nxt_n = and_v[15];
        nxt_z = (and_v == 16'h0000);
        res_v = and_v;
        wb_en = 1'b1;
      end
      `DSA_OP_BRA_GTU, `DSA_OP_BRA_GEU, `DSA_OP_BRA_GT, `DSA_OP_BRA_GE: begin
        // unsigned conditions from C and Z
        // signed conditions from N, OV, Z
        case (op)
          `DSA_OP_BRA_GTU: br_cond = c_ff & ~z_ff;
          `DSA_OP_BRA_GEU: br_cond = c_ff;
          `DSA_OP_BRA_GT: br_cond = ~z_ff & (n_ff == ov_ff);
          default: br_cond = (n_ff == ov_ff);
        endcase
        nxt_taken = br_cond;
        nxt_cyc = br_cond ? `DSA_CYC_TAKEN : `DSA_CYC_ONE;
      end
      `DSA_OP_ADD_ACC: begin
        acc_en = 1'b1;
      end
      `DSA_OP_MAC, `DSA_OP_SQR: begin
        acc_en = pair_ok;
        pf_en = pair_ok;
        nxt_err = err_ff | ~pair_ok;
      end
      `DSA_OP_NOP: begin
        nxt_err = err_ff;
      end
      default: begin
        nxt_err = 1'b1;
      end
    endcase
    // file result to W0 when selected
    if (wb_en) begin
      nxt_result = res_v;
      if (is_f) begin
        if (dsel) begin
          nxt_w[`DSA_R_W0] = res_v;
        end
      end else if (op == `DSA_OP_BIT_CLEAR_OP_W) begin
        if (smode == `DSA_SM_DIR) begin
          nxt_w[rs] = res_v;
        end
      end else begin
        nxt_w[rd] = res_v;
      end
    end
    if (acc_en && dsel) begin
      nxt_accb = acc_r[39:0];
      nxt_ob = acc_r[40];
      nxt_sb = sb_ff | acc_r[41];
    end else if (acc_en) begin
      nxt_acca = acc_r[39:0];
      nxt_oa = acc_r[40];
      nxt_sa = sa_ff | acc_r[41];
    end
    // X pointer, step, index or none
    if (pf_en && xm == `DSA_PF_IDX) begin
      nxt_xaddr = w_ff[`DSA_R_X1] + w_ff[`DSA_R_IDX];
    end else if (pf_en && xm != `DSA_PF_NONE) begin
      nxt_xaddr = w_ff[xp];
      nxt_w[xp] = w_ff[xp] + pf_delta(xsub[2:0]);
    end
    // Y pointer, step, index or none
    if (pf_en && ym == `DSA_PF_IDX) begin
      nxt_yaddr = w_ff[`DSA_R_Y1] + w_ff[`DSA_R_IDX];
    end else if (pf_en && ym != `DSA_PF_NONE) begin
      nxt_yaddr = w_ff[yp];
      nxt_w[yp] = w_ff[yp] + pf_delta(ysub[2:0]);
    end
    if (pf_en && xm != `DSA_PF_NONE) begin
      nxt_w[{2'b01, pf_ff[`DSA_PF_XDST]}] = xdata_ff;
    end
    if (pf_en && ym != `DSA_PF_NONE) begin
      nxt_w[{2'b01, pf_ff[`DSA_PF_YDST]}] = ydata_ff;
    end
  end

  // ************************************************************
  // Bus slave
  // ************************************************************
  wire busy = (state_ff != ST_IDLE);
  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire rd_fire = dph_valid_ff & ~dph_write_ff & ~busy & ~rd_done_ff;
  wire wr_fire = dph_valid_ff & dph_write_ff & ~busy & dph_word_ff;
  wire [31:0] status_w = {10'h000, cyc_ff, 1'b0, busy, err_ff, taken_ff, 4'h0,
                          sb_ff, sa_ff, ob_ff, oa_ff, 3'h0, dc_ff, n_ff, ov_ff, z_ff, c_ff};

  // Reads wait one cycle, everything waits while executing
  assign o_hreadyout = ~dph_valid_ff | (~busy & (dph_write_ff | rd_done_ff));
  assign o_hrdata = hrdata_ff;
  assign o_hresp = 1'b0;

  // Read data selection
  always @* begin
    rd_mux = 32'h0000_0000;
    case (dph_addr_ff)
      `DSA_A_CMD: rd_mux = {7'h00, cmd_ff};
      `DSA_A_PF: rd_mux = {18'h0_0000, pf_ff};
      `DSA_A_FDATA: rd_mux = {16'h0000, fdata_ff};
      `DSA_A_XDATA: rd_mux = {16'h0000, xdata_ff};
      `DSA_A_YDATA: rd_mux = {16'h0000, ydata_ff};
      `DSA_A_STATUS: rd_mux = status_w;
      `DSA_A_RESULT: rd_mux = {16'h0000, result_ff};
      `DSA_A_PFADDR: rd_mux = {yaddr_ff, xaddr_ff};
      `DSA_A_ACCA_LO: rd_mux = acca_ff[31:0];
      `DSA_A_ACCA_HI: rd_mux = {24'h00_0000, acca_ff[39:32]};
      `DSA_A_ACCB_LO: rd_mux = accb_ff[31:0];
      `DSA_A_ACCB_HI: rd_mux = {24'h00_0000, accb_ff[39:32]};
      default: begin
        if (dph_addr_ff[7:6] == `DSA_A_WWIN) begin
          rd_mux = {16'h0000, w_ff[dph_addr_ff[5:2]]};
        end
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      for (j = 0; j < 16; j = j + 1) begin
        w_ff[j] <= `DSA_RST_W;
      end
      cmd_ff <= {`DSA_CMD_W{1'b0}};
      pf_ff <= {`DSA_PF_W{1'b1}};
      {fdata_ff, xdata_ff, ydata_ff} <= {3{`DSA_RST_W}};
      {result_ff, xaddr_ff, yaddr_ff} <= {3{`DSA_RST_W}};
      acca_ff <= `DSA_RST_ACC;
      accb_ff <= `DSA_RST_ACC;
      {c_ff, z_ff, ov_ff, n_ff, dc_ff, oa_ff, ob_ff, sa_ff, sb_ff} <= 9'h000;
      taken_ff <= 1'b0;
      err_ff <= 1'b0;
      cyc_ff <= 2'h0;
      state_ff <= ST_IDLE;
      {dph_valid_ff, dph_write_ff, dph_word_ff, rd_done_ff} <= 4'h0;
      dph_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      // Address phase capture
      if (i_hready) begin
        dph_valid_ff <= addr_ok;
        dph_write_ff <= i_hwrite;
        dph_addr_ff <= i_haddr[7:0];
        dph_word_ff <= (i_hsize == `DSA_HSIZE_WORD);
      end
      rd_done_ff <= rd_fire;
      if (rd_fire) begin
        hrdata_ff <= rd_mux;
      end
      // Execution sequence
      case (state_ff)
        ST_IDLE: begin
          if (wr_fire && dph_addr_ff == `DSA_A_CMD) begin
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // taken branch adds a dead cycle
          state_ff <= nxt_taken ? ST_NOP : ST_IDLE;
          for (j = 0; j < 16; j = j + 1) begin
            w_ff[j] <= nxt_w[j];
          end
          {c_ff, z_ff, ov_ff, n_ff, dc_ff} <= {nxt_c, nxt_z, nxt_ov, nxt_n, nxt_dc};
          {oa_ff, ob_ff, sa_ff, sb_ff} <= {nxt_oa, nxt_ob, nxt_sa, nxt_sb};
          taken_ff <= nxt_taken;
          err_ff <= nxt_err;
          cyc_ff <= nxt_cyc;
          result_ff <= nxt_result;
          acca_ff <= nxt_acca;
          accb_ff <= nxt_accb;
          xaddr_ff <= nxt_xaddr;
          yaddr_ff <= nxt_yaddr;
        end
        ST_NOP: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
      // Software writes, only while idle
      if (wr_fire) begin
        case (dph_addr_ff)
          `DSA_A_CMD: cmd_ff <= i_hwdata[`DSA_CMD_W-1:0];
          `DSA_A_PF: pf_ff <= i_hwdata[`DSA_PF_W-1:0];
          `DSA_A_FDATA: fdata_ff <= i_hwdata[15:0];
          `DSA_A_XDATA: xdata_ff <= i_hwdata[15:0];
          `DSA_A_YDATA: ydata_ff <= i_hwdata[15:0];
          `DSA_A_STATUS: begin
            {dc_ff, n_ff, ov_ff, z_ff, c_ff} <= i_hwdata[`DSA_ST_DC:`DSA_ST_C];
            {sb_ff, sa_ff, ob_ff, oa_ff} <= i_hwdata[`DSA_ST_SB:`DSA_ST_OA];
            err_ff <= 1'b0;
          end
          `DSA_A_ACCA_LO: acca_ff[31:0] <= i_hwdata;
          `DSA_A_ACCA_HI: acca_ff[39:32] <= i_hwdata[7:0];
          `DSA_A_ACCB_LO: accb_ff[31:0] <= i_hwdata;
          `DSA_A_ACCB_HI: accb_ff[39:32] <= i_hwdata[7:0];
          default: begin
            if (dph_addr_ff[7:6] == `DSA_A_WWIN) begin
              w_ff[dph_addr_ff[5:2]] <= i_hwdata[15:0];
            end
          end
        endcase
      end
    end
  end
endmodule

// ### tb/dsa_core_sva.sv
// Bus-side assertions for the dsp operand and alu slice
`timescale 1ns/1ps
module dsa_core_sva (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp
);
  logic tk;
  logic rd_ff;
  logic cmd_ff;
  logic unm_ff;
  logic half_ff;
  // Address phase taken by the slave
  assign tk = i_hsel && i_htrans[1] && i_hready;
  // Kind of transfer now in its data phase
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      rd_ff <= 1'b0;
      cmd_ff <= 1'b0;
    end else if (tk) begin
      rd_ff <= !i_hwrite;
      cmd_ff <= i_hwrite && i_haddr[7:0] == 8'h00;
      unm_ff <= i_haddr[7] || i_haddr[7:4] == 4'h3;
      half_ff <= i_haddr[6] || (i_haddr[7:0] inside {8'h08, 8'h0C, 8'h10, 8'h18});
    end else if (o_hreadyout) begin
      rd_ff <= 1'b0;
      cmd_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  chk_resp_okay: assert property (o_hresp == 1'b0)
    else $error("bus response not okay");
  chk_rd_wait: assert property (tk && !i_hwrite |=> !o_hreadyout)
    else $error("read without its wait state");
  chk_rd_bound: assert property (tk && !i_hwrite |-> ##[2:4] o_hreadyout)
    else $error("read answer late");
  chk_rdata_hold: assert property (!rd_ff |=> $stable(o_hrdata))
    else $error("read data moved without a read");
  chk_unmap_zero: assert property (rd_ff && unm_ff && o_hreadyout
    |-> o_hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_half_zero: assert property (rd_ff && half_ff && o_hreadyout
    |-> o_hrdata[31:16] == 16'h0000)
    else $error("upper half of a word register not zero");
  chk_reset_out: assert property ($rose(i_resetn) |-> o_hreadyout && o_hrdata == 32'h0000_0000)
    else $error("bus outputs not at reset values");
  chk_exec_bound: assert property (cmd_ff && o_hreadyout |-> ##[1:3] o_hreadyout)
    else $error("execution held the bus too long");
endmodule

bind dsa_core dsa_core_sva chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
  .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp));

// ### tb/dsa_host.sv
// Bus master model standing in for the decoder side of the slice
`timescale 1ns/1ps
module dsa_host (
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata
);
  // Idle bus at time zero, the one slave always selected
  initial begin
    o_hsel = 1'b1;
    o_haddr = 32'h0000_0000;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hsize = 3'b010;
    o_hwdata = 32'h0000_0000;
  end
  // One single word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    o_htrans <= 2'b10;
    o_haddr <= {24'h00_0000, a};
    o_hwrite <= w;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    o_htrans <= 2'b00;
    o_hwdata <= d;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    q = i_hrdata;
  endtask
endmodule

// ### tb/dsa_core_test.sv
// Self-checking bench for the dsp operand and alu slice
`timescale 1ns/1ps
`include "dsa_map.vh"
`define CHK(g, e) \
  n_compared++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end
module dsa_core_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int mismatches = 0;
  int n_compared = 0;
  dsa_core dut (.i_clk(clk), .i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));
  dsa_host host (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
    .o_hwdata(hwdata));
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0000_0000, q);
    `CHK(q & m, e)
  endtask
  function automatic logic [7:0] wa(input logic [3:0] n);
    return {`DSA_A_WWIN, n, 2'b00};
  endfunction
  function automatic logic [31:0] cmd(input logic [4:0] op, input logic ds,
      input logic [3:0] rb, input logic [3:0] rs, input logic [3:0] rd, input logic [4:0] lit);
    return {7'h00, lit, rd, rs, rb, 2'b00, ds, op};
  endfunction
  // Register add with overflow, then carry add of a literal
  task automatic t_add;
    wr(wa(4'h1), 32'h0000_7FFF);
    wr(wa(4'h2), 32'h0000_0001);
    wr(`DSA_A_CMD, cmd(`DSA_OP_ADD_RR, 1'b0, 4'h1, 4'h2, 4'hF, 5'h00));
    rdc(wa(4'hF), 32'h0000_8000);
    rdc(`DSA_A_STATUS, 32'h0010_001C);
    wr(`DSA_A_STATUS, 32'h0000_0001);
    wr(`DSA_A_CMD, cmd(`DSA_OP_ADD_WITH_CARRY_OP_L5, 1'b0, 4'hF, 4'h0, 4'hE, 5'h1F));
    rdc(wa(4'hE), 32'h0000_8020);
    rdc(`DSA_A_STATUS, 32'h0010_0018);
  endtask
  // File ops into W0, shifts, read-only and unmapped places
  task automatic t_file;
    wr(wa(4'h0), 32'h0000_0001);
    wr(`DSA_A_FDATA, 32'h0000_FFFF);
    wr(`DSA_A_CMD, cmd(`DSA_OP_ADD_F, 1'b1, 4'h0, 4'h0, 4'h0, 5'h00));
    rdc(wa(4'h0), 32'h0000_0000);
    rdc(`DSA_A_STATUS, 32'h0010_0013);
    wr(`DSA_A_STATUS, 32'h0000_0015);
    wr(`DSA_A_CMD, cmd(`DSA_OP_ASR_L, 1'b0, 4'hE, 4'h0, 4'hD, 5'h04));
    rdc(wa(4'hD), 32'h0000_F802);
    rdc(`DSA_A_STATUS, 32'h0010_001D);
    wr(`DSA_A_STATUS, 32'h0000_0010);
    wr(`DSA_A_FDATA, 32'h0000_0003);
    wr(`DSA_A_CMD, cmd(`DSA_OP_ASR_F, 1'b0, 4'h0, 4'h0, 4'h0, 5'h00));
    rdc(`DSA_A_RESULT, 32'h0000_0001);
    rdc(`DSA_A_STATUS, 32'h0010_0011);
    wr(`DSA_A_STATUS, 32'h0000_0001);
    wr(`DSA_A_CMD, cmd(`DSA_OP_ASR_W, 1'b0, 4'hE, 4'h1, 4'hC, 5'h00));
    rdc(wa(4'hC), 32'h0000_FFFF);
    rdc(`DSA_A_STATUS, 32'h0010_0009);
    wr(`DSA_A_RESULT, 32'h0000_DEAD);
    rdc(`DSA_A_RESULT, 32'h0000_FFFF);
    rdc(8'h30, 32'h0000_0000);
  endtask
  // Products with prefetch, every pair and square code, a bad code
  task automatic t_mac;
    int v[4] = '{2, 3, 5, 7};
    int pm[6] = '{0, 0, 0, 1, 1, 2};
    int pn[6] = '{1, 2, 3, 2, 3, 3};
    int sa = 15;
    int sb = 0;
    wr(wa(4'h4), 32'h0000_0003);
    wr(wa(4'h5), 32'h0000_0005);
    wr(wa(4'h8), 32'h0000_0100);
    wr(wa(4'hB), 32'h0000_0200);
    wr(wa(4'hC), 32'h0000_0010);
    wr(`DSA_A_XDATA, 32'h0000_1234);
    wr(`DSA_A_YDATA, 32'h0000_ABCD);
    wr(`DSA_A_PF, 32'h0000_3E23);
    wr(`DSA_A_CMD, cmd(`DSA_OP_MAC, 1'b0, 4'h0, 4'h0, 4'h0, 5'h00));
    rdc(`DSA_A_ACCA_LO, 32'h0000_000F);
    rdc(wa(4'h6), 32'h0000_1234);
    rdc(wa(4'h7), 32'h0000_ABCD);
    rdc(wa(4'h8), 32'h0000_0106);
    rdc(`DSA_A_PFADDR, 32'h0210_0100);
    rdc(`DSA_A_STATUS, 32'h0010_0009);
    wr(`DSA_A_PF, 32'h0000_0F0F);
    for (int k = 0; k < 4; k++) wr(wa(4'(4 + k)), 32'(v[k]));
    for (int k = 0; k < 6; k++) begin
      sa += v[pm[k]] * v[pn[k]];
      wr(`DSA_A_CMD, cmd(`DSA_OP_MAC, 1'b0, 4'h0, 4'(k), 4'h0, 5'h00));
      rdc(`DSA_A_ACCA_LO, 32'(sa));
    end
    for (int k = 0; k < 4; k++) begin
      sb += v[k] * v[k];
      wr(`DSA_A_CMD, cmd(`DSA_OP_SQR, 1'b1, 4'h0, 4'(k), 4'h0, 5'h00));
      rdc(`DSA_A_ACCB_LO, 32'(sb));
    end
    wr(`DSA_A_CMD, cmd(`DSA_OP_MAC, 1'b0, 4'h0, 4'h6, 4'h0, 5'h00));
    rdc(`DSA_A_ACCA_LO, 32'(sa));
    rdc(`DSA_A_STATUS, 32'h0002_0000, 32'h0002_0000);
  endtask
  // Four compare branches, each taken, all but GE also not taken
  task automatic t_branch;
    logic [4:0] ops[4] = '{`DSA_OP_BRA_GTU, `DSA_OP_BRA_GEU, `DSA_OP_BRA_GT, `DSA_OP_BRA_GE};
    logic tk;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        tk = (p == 0) || (i == 3);
        wr(`DSA_A_STATUS, p ? 32'h0000_0002 : 32'h0000_0001);
        wr(`DSA_A_CMD, cmd(ops[i], 1'b0, 4'h0, 4'h0, 4'h0, 5'h00));
        rdc(`DSA_A_STATUS, {10'h000, 2'(tk + 1), 3'h0, tk, 12'h000, 4'(p + 1)});
      end
    end
  endtask
  // Source through a post-increment mode, accumulator add, bit clear in place
  task automatic t_mode;
    wr(`DSA_A_CMD, cmd(`DSA_OP_ASR_RR, 1'b0, 4'h0, 4'h3, 4'h9, 5'h00) | 32'h0000_0080);
    rdc(wa(4'h9), 32'h0000_0001);
    rdc(wa(4'h3), 32'h0000_0002);
    rdc(`DSA_A_STATUS, 32'h0000_0001, 32'h0000_0F1F);
    wr(`DSA_A_CMD, cmd(`DSA_OP_ADD_ACC, 1'b1, 4'h0, 4'h9, 4'h0, 5'h01));
    rdc(`DSA_A_ACCB_LO, 32'h0000_8057);
    rdc(`DSA_A_STATUS, 32'h0000_0001, 32'h0000_0F1F);
    wr(`DSA_A_CMD, cmd(`DSA_OP_BIT_CLEAR_OP_W, 1'b0, 4'h0, 4'h9, 4'h0, 5'h00));
    rdc(wa(4'h9), 32'h0000_0000);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rdc(wa(4'h3), 32'h0000_0000);
    rdc(`DSA_A_STATUS, 32'h0000_0000, 32'h0003_0F1F);
    t_add();
    t_file();
    t_mac();
    t_branch();
    t_mode();
    report_and_stop();
  end
  // Watchdog against a hung handshake
  initial begin
    #(50 * 5000);
    mismatches++;
    report_and_stop();
  end
endmodule
